// file: verification/tb.sv
// Self-checking bench of the receive status and baud block.
`timescale 1ns/100ps
module tb;
    logic ref_clk_i, sys_rst_i, cpu_rd_i, cpu_wr_i, cpu_rdata_valid_o;
    logic rx_done_i, rx_buf_read_i, async_mode_i, timer_wave_i, ext_clk_i;
    logic sample_tick_o, bit_tick_o;
    logic [15:0] cpu_addr_i, g;
    logic [7:0] cpu_wdata_i, cpu_rdata_o;
    logic [3:0] source_select_o;
    urbg_pkg::urbg_frame_t rx_frame_i;
    urbg_pkg::urbg_format_t rx_format_i;
    urbg_pkg::urbg_status_t rx_status_o;
    int n_fail = 0, checked = 0, cyc = 0, k;
    // Rows are format, frame as data-parity-stop, expected flags.
    logic [16:0] rows [9] = '{{4'hC, 10'h005, 3'h0}, {4'hC, 10'h007, 3'h4},
        {4'hE, 10'h005, 3'h4}, {4'hE, 10'h00C, 3'h2}, {4'hA, 10'h007, 3'h0},
        {4'h8, 10'h005, 3'h0}, {4'h4, 10'h205, 3'h0}, {4'hD, 10'h005, 3'h0},
        {4'hD, 10'h004, 3'h2}};
    urbg_top u_dut (.ref_clk_i, .sys_rst_i, .cpu_addr_i, .cpu_rd_i, .cpu_wr_i, .cpu_wdata_i,
        .cpu_rdata_o, .cpu_rdata_valid_o, .rx_done_i, .rx_frame_i, .rx_format_i,
        .rx_buf_read_i, .async_mode_i, .timer_wave_i, .ext_clk_i, .rx_status_o,
        .source_select_o, .sample_tick_o, .bit_tick_o);
    urbg_peer u_peer (.ref_clk_i, .rx_done_o(rx_done_i), .rx_frame_o(rx_frame_i),
        .rx_format_o(rx_format_i), .timer_wave_o(timer_wave_i), .ext_clk_o(ext_clk_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask : chk
    task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        cpu_addr_i <= a;
        cpu_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        cpu_rd_i <= 1'b0;
        @(negedge ref_clk_i);
        chk("read valid", 16'h0001, {15'h0000, cpu_rdata_valid_o});
        chk("read data", {8'h00, e}, {8'h00, cpu_rdata_o});
    endtask : reg_rd
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        cpu_addr_i <= a;
        cpu_wdata_i <= d;
        cpu_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        cpu_wr_i <= 1'b0;
    endtask : reg_wr
    task automatic buf_rd(input logic [15:0] e);
        @(posedge ref_clk_i);
        rx_buf_read_i <= 1'b1;
        @(posedge ref_clk_i);
        rx_buf_read_i <= 1'b0;
        @(negedge ref_clk_i);
        chk("flags after read", e, {13'h0000, rx_status_o});
    endtask : buf_rd
    // Skips ticks of the old setting, then counts cycles between two ticks.
    task automatic gap(input bit b, output logic [15:0] n);
        repeat (3) @(negedge ref_clk_i);
        n = 16'h0000;
        while ((b ? bit_tick_o : sample_tick_o) !== 1'b1 && n < 16'h0384) begin
            @(negedge ref_clk_i);
            n++;
        end
        n = 16'h0000;
        do begin
            @(negedge ref_clk_i);
            n++;
        end while ((b ? bit_tick_o : sample_tick_o) !== 1'b1 && n < 16'h0384);
    endtask : gap
    task automatic quiet(output logic [15:0] n);
        repeat (3) @(negedge ref_clk_i);
        n = 16'h0000;
        repeat (100) begin
            @(negedge ref_clk_i);
            n = n + {15'h0000, sample_tick_o === 1'b1};
        end
    endtask : quiet
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_rst_i = 1'b1;
        cpu_addr_i = 16'h0000;
        cpu_rd_i = 1'b0;
        cpu_wr_i = 1'b0;
        cpu_wdata_i = 8'h00;
        rx_buf_read_i = 1'b0;
        async_mode_i = 1'b0;
        repeat (8) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        reg_rd(16'hFF71, 8'h00);
        reg_rd(16'hFF73, 8'h00);
        reg_rd(16'hFF72, 8'h00);
        for (k = 0; k < 9; k++) begin
            u_peer.send(rows[k][16:13], rows[k][12:3]);
            @(negedge ref_clk_i);
            chk("flags", {13'h0000, rows[k][2:0]}, {13'h0000, rx_status_o});
            reg_rd(16'hFF71, {5'h00, rows[k][2:0]});
            buf_rd(16'h0000);
        end
        u_peer.send(4'h8, 10'h004);
        u_peer.send(4'h8, 10'h005);
        @(negedge ref_clk_i);
        chk("overrun", 16'h0001, {13'h0000, rx_status_o});
        u_peer.send(4'h8, 10'h005);
        @(negedge ref_clk_i);
        chk("overrun kept", 16'h0001, {13'h0000, rx_status_o});
        // A buffer read in the cycle of a new frame drains the old byte, so no overrun.
        fork
            u_peer.send(4'h8, 10'h004);
            buf_rd(16'h0002);
        join
        buf_rd(16'h0000);
        reg_wr(16'hFF71, 8'hFF);
        reg_rd(16'hFF71, 8'h00);
        reg_wr(16'hFF73, 8'h9F);
        reg_rd(16'hFF73, 8'h90);
        quiet(g);
        chk("prohibited ticks", 16'h0000, g);
        for (k = 0; k < 7; k++) begin
            reg_wr(16'hFF73, {k[3:0], 4'h0});
            gap(1'b0, g);
            chk("sys tick period", 16'(4 << k), g);
        end
        reg_wr(16'hFF73, 8'h00);
        gap(1'b1, g);
        chk("bit tick period", 16'h0040, g);
        reg_wr(16'hFF73, 8'h70);
        gap(1'b0, g);
        chk("timer tick period", 16'h0014, g);
        reg_wr(16'hFF73, 8'h80);
        quiet(g);
        chk("pin ticks outside async", 16'h0000, g);
        @(posedge ref_clk_i);
        async_mode_i <= 1'b1;
        gap(1'b0, g);
        chk("pin tick period", 16'h001E, g);
        // A reset in mid-run must clear a raised flag and a non-zero select code.
        u_peer.send(4'h8, 10'h004);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        reg_rd(16'hFF71, 8'h00);
        reg_rd(16'hFF73, 8'h00);
        conclude();
    end
endmodule : tb
bind urbg_top urbg_chk u_chk (.ref_clk_i, .sys_rst_i, .cpu_addr_i, .cpu_rd_i, .cpu_wr_i,
    .cpu_wdata_i, .cpu_rdata_o, .cpu_rdata_valid_o, .rx_done_i, .rx_frame_i, .rx_buf_read_i,
    .async_mode_i, .rx_status_o, .source_select_o, .sample_tick_o, .bit_tick_o);

// file: verification/urbg_chk.sv
// Concurrent checks on the ports of the receive status and baud block.
`timescale 1ns/100ps
module urbg_chk (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic cpu_rd_i,
    input wire logic cpu_wr_i,
    input wire logic [7:0] cpu_wdata_i,
    input wire logic [7:0] cpu_rdata_o,
    input wire logic cpu_rdata_valid_o,
    input wire logic rx_done_i,
    input wire urbg_pkg::urbg_frame_t rx_frame_i,
    input wire logic rx_buf_read_i,
    input wire logic async_mode_i,
    input wire urbg_pkg::urbg_status_t rx_status_o,
    input wire logic [3:0] source_select_o,
    input wire logic sample_tick_o,
    input wire logic bit_tick_o
);
    logic [3:0] wr_hi;
    logic stop_in;
    assign wr_hi = cpu_wdata_i[7:4];
    assign stop_in = rx_frame_i.stop_bit;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sequence s_rd_stat; cpu_rd_i && cpu_addr_i == 16'hFF71; endsequence
    sequence s_rd_sel; cpu_rd_i && cpu_addr_i == 16'hFF73; endsequence
    sequence s_quiet_then_tick; !sample_tick_o [*3] ##1 sample_tick_o; endsequence
    property p_rd_valid; cpu_rd_i |=> cpu_rdata_valid_o; endproperty
    property p_stat_rd; s_rd_stat |=> cpu_rdata_o == {5'h00, $past(rx_status_o)}; endproperty
    property p_sel_rd; s_rd_sel |=> cpu_rdata_o == {$past(source_select_o), 4'h0}; endproperty
    property p_sel_wr; cpu_wr_i && cpu_addr_i == 16'hFF73 |=> source_select_o == $past(wr_hi);
    endproperty
    property p_fe; rx_done_i |=> rx_status_o.framing_error_flag != $past(stop_in); endproperty
    property p_clr; rx_buf_read_i && !rx_done_i |=> rx_status_o == 3'h0; endproperty
    property p_ove; rx_done_i && rx_status_o.overrun_error_flag && !rx_buf_read_i
        |=> rx_status_o.overrun_error_flag; endproperty
    property p_hold; !rx_done_i && !rx_buf_read_i |=> $stable(rx_status_o); endproperty
    property p_tick0;
        disable iff (sys_rst_i || cpu_wr_i)
        sample_tick_o && source_select_o == 4'h0 && !cpu_wr_i && !$past(cpu_wr_i)
            |=> s_quiet_then_tick;
    endproperty
    property p_prohib; source_select_o > 4'h8 && $stable(source_select_o) |-> !sample_tick_o;
    endproperty
    property p_gate; (source_select_o == 4'h8 && !async_mode_i) [*6] |-> !sample_tick_o;
    endproperty
    property p_bit; bit_tick_o |-> sample_tick_o; endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("read answer missing");
    a_stat_rd: assert property (p_stat_rd)
        else $error("status read value wrong");
    a_sel_rd: assert property (p_sel_rd)
        else $error("select read value wrong");
    a_sel_wr: assert property (p_sel_wr)
        else $error("select write not stored");
    a_fe: assert property (p_fe)
        else $error("framing flag wrong");
    a_clr: assert property (p_clr)
        else $error("buffer read did not clear flags");
    a_ove: assert property (p_ove)
        else $error("overrun not kept");
    a_hold: assert property (p_hold)
        else $error("flags changed without cause");
    a_tick0: assert property (p_tick0)
        else $error("tick period for code zero wrong");
    a_prohib: assert property (p_prohib)
        else $error("tick on prohibited code");
    a_gate: assert property (p_gate)
        else $error("pin clock used outside async mode");
    a_bit: assert property (p_bit)
        else $error("bit tick without sample tick");
endmodule : urbg_chk

// file: verification/urbg_peer.sv
// Model of the far transmitter and of the timer and pin clock sources.
`timescale 1ns/100ps
module urbg_peer (
    input wire logic ref_clk_i,
    output logic rx_done_o,
    output urbg_pkg::urbg_frame_t rx_frame_o,
    output urbg_pkg::urbg_format_t rx_format_o,
    output logic timer_wave_o,
    output logic ext_clk_o
);
    initial begin
        rx_done_o = 1'b0;
        rx_frame_o = '0;
        rx_format_o = '0;
    end
    // Timer in square-wave mode, 200 ns period, its edges falling on falling clock edges.
    initial begin
        timer_wave_o = 1'b0;
        forever #100 timer_wave_o = ~timer_wave_o;
    end
    // Pin clock, 300 ns period, fed to a pin set as input.
    initial begin
        ext_clk_o = 1'b0;
        forever #150 ext_clk_o = ~ext_clk_o;
    end
    task automatic send(input logic [3:0] fmt, input logic [9:0] frm);
        @(posedge ref_clk_i);
        rx_done_o <= 1'b1;
        rx_frame_o <= frm;
        rx_format_o <= fmt;
        @(posedge ref_clk_i);
        rx_done_o <= 1'b0;
        // The frame is stale once the pulse is gone, so show other bits.
        rx_frame_o <= ~frm;
    endtask : send
endmodule : urbg_peer

// file: verilog/urbg_baud_gen.sv
// Baud source selection and sampling tick generator.
`timescale 1ns/100ps
module urbg_baud_gen (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] source_select_i,
    input wire logic restart_i,
    input wire logic async_mode_i,
    input wire logic timer_wave_i,
    input wire logic ext_clk_i,
    output logic sample_tick_o,
    output logic bit_tick_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Terminal count of the prescaler: the sampling tick is the system clock over 2 to the n.
    function automatic logic [7:0] urbg_prescale_last(input logic [3:0] code);
        int n;
        n = int'(code) + urbg_pkg::URBG_SYS_N_BASE;
        return 8'((1 << n) - 1);
    endfunction : urbg_prescale_last

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [2:0] timer_sync_q, timer_sync_d;
    logic [2:0] ext_sync_q, ext_sync_d;
    logic [7:0] prescale_q, prescale_d;
    logic [3:0] sample_cnt_q, sample_cnt_d;
    logic sample_tick_q, sample_tick_d;
    logic bit_tick_q, bit_tick_d;
    logic src_edge;

    always_comb begin
        timer_sync_d = {timer_sync_q[1:0], timer_wave_i};
        ext_sync_d = {ext_sync_q[1:0], ext_clk_i};
    end

    // ------------------------------------------------------------------
    // Source selection and dividers
    // ------------------------------------------------------------------
    always_comb begin
        src_edge = 1'b0;
        prescale_d = urbg_pkg::URBG_PRESCALE_RESET;
        // Each rising edge of the timer or pin is one sampling tick, so a bit is 16 edges.
        if (source_select_i <= urbg_pkg::URBG_SEL_SYS_LAST) begin
            if (prescale_q >= urbg_prescale_last(source_select_i)) begin
                src_edge = 1'b1;
            end else begin
                prescale_d = prescale_q + 8'h01;
            end
        end else if (source_select_i == urbg_pkg::URBG_SEL_TIMER) begin
            src_edge = timer_sync_q[1] & ~timer_sync_q[2];
        end else if (source_select_i == urbg_pkg::URBG_SEL_EXT_PIN) begin
            // The pin clock is honoured in asynchronous mode only.
            src_edge = async_mode_i & ext_sync_q[1] & ~ext_sync_q[2];
        end
        // Prohibited codes produce no tick at all, which keeps a bad setting visible.
        sample_tick_d = src_edge & ~restart_i;
        sample_cnt_d = sample_cnt_q;
        bit_tick_d = 1'b0;
        if (sample_tick_d) begin
            sample_cnt_d = sample_cnt_q + 4'h1;
            bit_tick_d = (sample_cnt_q == urbg_pkg::URBG_SAMPLE_LAST);
        end
        // Any write of the select code restarts both dividers from zero.
        if (restart_i) begin
            prescale_d = urbg_pkg::URBG_PRESCALE_RESET;
            sample_cnt_d = urbg_pkg::URBG_SAMPLE_CNT_RESET;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            timer_sync_q <= 3'h0;
            ext_sync_q <= 3'h0;
            prescale_q <= urbg_pkg::URBG_PRESCALE_RESET;
            sample_cnt_q <= urbg_pkg::URBG_SAMPLE_CNT_RESET;
            sample_tick_q <= 1'b0;
            bit_tick_q <= 1'b0;
        end else begin
            timer_sync_q <= timer_sync_d;
            ext_sync_q <= ext_sync_d;
            prescale_q <= prescale_d;
            sample_cnt_q <= sample_cnt_d;
            sample_tick_q <= sample_tick_d;
            bit_tick_q <= bit_tick_d;
        end
    end

    assign sample_tick_o = sample_tick_q;
    assign bit_tick_o = bit_tick_q;

endmodule : urbg_baud_gen

// file: verilog/urbg_pkg.sv
// Package with register map, field layout and carrier types of the receive status and baud block.
package urbg_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] URBG_ADDR_RX_STATUS = 16'hFF71;
    localparam logic [15:0] URBG_ADDR_BAUD_SEL = 16'hFF73;
    localparam logic [7:0] URBG_RX_STATUS_RESET = 8'h00;
    localparam logic [3:0] URBG_BAUD_SEL_RESET = 4'h0;
    localparam logic [7:0] URBG_READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int URBG_BIT_OVERRUN = 0;
    localparam int URBG_BIT_FRAMING = 1;
    localparam int URBG_BIT_PARITY = 2;
    localparam int URBG_SEL_LSB = 4;
    localparam int URBG_SEL_MSB = 7;

    // ------------------------------------------------------------------
    // Source select codes and divider figures
    // ------------------------------------------------------------------
    localparam logic [3:0] URBG_SEL_SYS_LAST = 4'h6;
    localparam logic [3:0] URBG_SEL_TIMER = 4'h7;
    localparam logic [3:0] URBG_SEL_EXT_PIN = 4'h8;
    localparam int URBG_SYS_N_BASE = 2;
    localparam int URBG_SAMPLES_PER_BIT = 16;
    localparam logic [3:0] URBG_SAMPLE_LAST = 4'(URBG_SAMPLES_PER_BIT - 1);
    localparam logic [7:0] URBG_PRESCALE_RESET = 8'h00;
    localparam logic [3:0] URBG_SAMPLE_CNT_RESET = 4'h0;

    // ------------------------------------------------------------------
    // Parity mode codes
    // ------------------------------------------------------------------
    localparam logic [1:0] URBG_PARITY_NONE = 2'h0;
    localparam logic [1:0] URBG_PARITY_ZERO = 2'h1;
    localparam logic [1:0] URBG_PARITY_ODD = 2'h2;
    localparam logic [1:0] URBG_PARITY_EVEN = 2'h3;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic parity_bit;
        logic stop_bit;
    } urbg_frame_t;

    typedef struct packed {
        logic char_len_8;
        logic [1:0] parity_mode;
        logic stop_length_select;
    } urbg_format_t;

    typedef struct packed {
        logic parity_error_flag;
        logic framing_error_flag;
        logic overrun_error_flag;
    } urbg_status_t;

endpackage : urbg_pkg

// file: verilog/urbg_top.sv
// Receive error status register and baud generator control register with their logic.
//
// Functional notes
// - Status register resets to zero, is read only, read as a whole byte.
// - Bit 2 flags a parity mismatch in the received frame.
// - Bit 1 flags a missing high stop bit.
// - Bit 0 flags a frame completed before the previous byte was read.
// - Reception checks only the first stop bit, whatever the stop length.
// - Overrun repeats on every completed frame until the buffer is read.
// - Codes 0 to 6 pick system clock over 2 to the n; above 8 prohibited.
// - System clock baud is clock over 2 to the n plus one, then over 8.
// - Code 7 takes the timer square wave, baud is its rate over 16.
// - Code 8 takes the external clock pin, baud is its rate over 16.
// - The pin clock source works only in asynchronous mode.
// - Baud control register resets to zero, system clock over 4.
// - A buffer read or a new frame clears all flags; new errors set theirs.
// - Frame is start, 7 or 8 data bits, optional parity, then stop.
`timescale 1ns/100ps
module urbg_top (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // CPU register port.
    input wire logic [15:0] cpu_addr_i,
    input wire logic cpu_rd_i,
    input wire logic cpu_wr_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic [7:0] cpu_rdata_o,
    output logic cpu_rdata_valid_o,
    // Receiver side.
    input wire logic rx_done_i,
    input wire urbg_pkg::urbg_frame_t rx_frame_i,
    input wire urbg_pkg::urbg_format_t rx_format_i,
    input wire logic rx_buf_read_i,
    input wire logic async_mode_i,
    // Clock sources from pins.
    input wire logic timer_wave_i,
    input wire logic ext_clk_i,
    // Status and timing to the shifters.
    output urbg_pkg::urbg_status_t rx_status_o,
    output logic [3:0] source_select_o,
    output logic sample_tick_o,
    output logic bit_tick_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // True when the received parity disagrees with the selected odd or even mode.
    function automatic logic urbg_parity_bad(
        input urbg_pkg::urbg_frame_t frame,
        input urbg_pkg::urbg_format_t fmt
    );
        logic [7:0] bits;
        logic ones_odd;
        bits = frame.data;
        // In 7-bit mode the top bit is not part of the character.
        if (!fmt.char_len_8) begin
            bits[7] = 1'b0;
        end
        ones_odd = (^bits) ^ frame.parity_bit;
        case (fmt.parity_mode)
            urbg_pkg::URBG_PARITY_ODD: return ~ones_odd;
            urbg_pkg::URBG_PARITY_EVEN: return ones_odd;
            default: return 1'b0;
        endcase
    endfunction : urbg_parity_bad

    // ------------------------------------------------------------------
    // Receive status
    // ------------------------------------------------------------------
    urbg_pkg::urbg_status_t status_q, status_d;
    logic unread_q, unread_d;
    urbg_pkg::urbg_status_t frame_status;

    always_comb begin
        frame_status.parity_error_flag = urbg_parity_bad(rx_frame_i, rx_format_i);
        // Only the first stop bit is carried in, so the second stop bit is never checked.
        frame_status.framing_error_flag = ~rx_frame_i.stop_bit;
        // A read in the same cycle drains the old byte, so the new frame is no overrun.
        frame_status.overrun_error_flag = unread_q & ~rx_buf_read_i;

        status_d = status_q;
        if (rx_buf_read_i) begin
            status_d = '0;
        end
        // A completing frame overrides the clear, so its errors are never lost.
        if (rx_done_i) begin
            status_d = frame_status;
        end

        unread_d = unread_q;
        if (rx_buf_read_i) begin
            unread_d = 1'b0;
        end
        if (rx_done_i) begin
            unread_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            status_q <= urbg_pkg::urbg_status_t'(urbg_pkg::URBG_RX_STATUS_RESET[2:0]);
            unread_q <= 1'b0;
        end else begin
            status_q <= status_d;
            unread_q <= unread_d;
        end
    end

    // ------------------------------------------------------------------
    // Baud control register
    // ------------------------------------------------------------------
    logic [3:0] sel_q, sel_d;
    logic sel_write_q, sel_write_d;
    logic sel_hit;

    always_comb begin
        sel_hit = cpu_wr_i && (cpu_addr_i == urbg_pkg::URBG_ADDR_BAUD_SEL);
        sel_d = sel_q;
        // Only the upper nibble is stored; the lower nibble is dropped.
        if (sel_hit) begin
            sel_d = cpu_wdata_i[urbg_pkg::URBG_SEL_MSB:urbg_pkg::URBG_SEL_LSB];
        end
        // Any write to the baud control register restarts the dividers, which is why writing mid-transfer breaks it.
        sel_write_d = sel_hit;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sel_q <= urbg_pkg::URBG_BAUD_SEL_RESET;
            sel_write_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            sel_write_q <= sel_write_d;
        end
    end

    // ------------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    always_comb begin
        rdata_d = urbg_pkg::URBG_READ_UNMAPPED;
        rvalid_d = cpu_rd_i;
        if (cpu_rd_i) begin
            case (cpu_addr_i)
                urbg_pkg::URBG_ADDR_RX_STATUS: begin
                    rdata_d = 8'h00;
                    rdata_d[urbg_pkg::URBG_BIT_PARITY] = status_q.parity_error_flag;
                    rdata_d[urbg_pkg::URBG_BIT_FRAMING] = status_q.framing_error_flag;
                    rdata_d[urbg_pkg::URBG_BIT_OVERRUN] = status_q.overrun_error_flag;
                end
                urbg_pkg::URBG_ADDR_BAUD_SEL: begin
                    rdata_d = {sel_q, 4'h0};
                end
                default: begin
                    rdata_d = urbg_pkg::URBG_READ_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= urbg_pkg::URBG_READ_UNMAPPED;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ------------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------------
    // The generator sees the newly stored code one cycle after the write, with its restart.
    urbg_baud_gen u_baud_gen (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .source_select_i(sel_q),
        .restart_i(sel_write_q),
        .async_mode_i(async_mode_i),
        .timer_wave_i(timer_wave_i),
        .ext_clk_i(ext_clk_i),
        .sample_tick_o(sample_tick_o),
        .bit_tick_o(bit_tick_o)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cpu_rdata_o = rdata_q;
    assign cpu_rdata_valid_o = rvalid_q;
    assign rx_status_o = status_q;
    assign source_select_o = sel_q;

endmodule : urbg_top
